/* verilog/ctmr_pkg.sv */
/*
  Shared constants of the compact timer: register map, field positions,
  mode and output-function codes, reset values.
  Assumes a single clock domain and an 8-bit register port.
*/
// Functional notes
// - Initial level, or PWM active level
// - Invert bit flips pin, not timer mode
// - Swap bit exchanges period and duty sources
// - Clear select: A match, else P/overflow
// - Overflow clear only when period is zero
// - PWM ignores clear select bit
// - Mode 00 compare, 10 PWM, 11 timer
// - Compare mode P-clear sets both flags
// - Outside PWM, A-clear never raises the P flag
// - Compare A zero: overflow, no A flag
// - Compare pin changes only on A match or timer-on rise
// - Function 00 leaves compare pin alone
// - Function 01 low, 10 high, 11 toggle
// - Timer-on rise restores initial pin level
// - Timer mode counts alike, pin undriven
// - PWM raises both flags on matches
// - PWM function enables wave or forces level
// - PWM 00 inactive, 01 active, 10 wave
// - PWM period 128 per code, 000 is 1024
// - Duty at or above period: always active
// - Swapped: period compare A, duty code
// - Forced pin keeps PWM counting and flags
// - Period clear starts a new PWM period
// - Period vs counter top bits; rise clears
`default_nettype none
package ctmr_pkg;
  localparam int CNT_W = 10;
  localparam int PER_W = 3;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PER_SHIFT = 7;
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_FLAGS = 3'h6;
  localparam int C0_ON_BIT = 3;
  localparam int C0_PER_LSB = 0;
  localparam int C1_MODE_LSB = 6;
  localparam int C1_OFN_LSB = 4;
  localparam int C1_INIT_BIT = 3;
  localparam int C1_INV_BIT = 2;
  localparam int C1_SWAP_BIT = 1;
  localparam int C1_CCS_BIT = 0;
  localparam int FLG_A_BIT = 0;
  localparam int FLG_P_BIT = 1;
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] OFN_LOW = 2'h1;
  localparam logic [1:0] OFN_HIGH = 2'h2;
  localparam logic [1:0] OFN_TOGGLE = 2'h3;
  localparam logic [1:0] OFN_PWM_ACT = 2'h1;
  localparam logic [1:0] OFN_PWM_WAVE = 2'h2;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [PER_W-1:0] PER_RST = 3'h0;
  localparam logic [CNT_W-1:0] CMPA_RST = 10'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 10'h000;
endpackage
`default_nettype wire

/* verilog/ctmr_out_if.sv */
/*
  Bundle between the counter core and the pin output generator.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
interface ctmr_out_if;
  logic [1:0] mode;
  logic [1:0] ofn;
  logic init_lvl;
  logic invert;
  logic on_rise;
  logic a_evt;
  logic pwm_active;
  logic pin_lvl;
  logic pin_en;
  modport core (output mode, ofn, init_lvl, invert, on_rise, a_evt,
    pwm_active, input pin_lvl, pin_en);
  modport gen (input mode, ofn, init_lvl, invert, on_rise, a_evt,
    pwm_active, output pin_lvl, pin_en);
endinterface
`default_nettype wire

/* verilog/ctmr_match.sv */
/*
  One equality comparator between the incremented count and a target.
  Assumes inputs from the same clock domain; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module ctmr_match #(
  parameter int W = 11
) (
  input wire logic [W-1:0] inc,
  input wire logic [W-1:0] target,
  input wire logic enable,
  output logic hit
);
  // Matching the next value lets the clear land in the same edge
  assign hit = enable && (inc == target);
endmodule
`default_nettype wire

/* verilog/ctmr_outgen.sv */
/*
  Output pin generator: compare-mode level keeping and PWM shaping.
  Assumes events and counter state from the core on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module ctmr_outgen (
  input wire logic clk_sys,
  input wire logic arst_n,
  ctmr_out_if.gen ob
);
  import ctmr_pkg::*;
  logic lvl_q;
  logic lvl_d;
  logic pwm_lvl;
  logic pin_d;

  always_comb begin
    lvl_d = lvl_q;
    if (ob.on_rise) begin
      lvl_d = ob.init_lvl;
    end else if (ob.mode == MODE_CMP && ob.a_evt) begin
      case (ob.ofn)
        OFN_LOW: lvl_d = 1'b0;
        OFN_HIGH: lvl_d = 1'b1;
        OFN_TOGGLE: lvl_d = ~lvl_q;
        default: lvl_d = lvl_q;
      endcase
    end
  end

  // Active level follows the initial-level bit in PWM
  always_comb begin
    case (ob.ofn)
      OFN_PWM_ACT: pwm_lvl = ob.init_lvl;
      OFN_PWM_WAVE: pwm_lvl = ob.pwm_active ? ob.init_lvl : ~ob.init_lvl;
      default: pwm_lvl = ~ob.init_lvl;
    endcase
  end

  assign pin_d = ((ob.mode == MODE_PWM) ? pwm_lvl : lvl_d) ^ ob.invert;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // Timer mode and the undefined code release the pin
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ob.pin_lvl <= 1'b0;
      ob.pin_en <= 1'b0;
    end else begin
      ob.pin_en <= (ob.mode == MODE_CMP) || (ob.mode == MODE_PWM);
      ob.pin_lvl <= (ob.mode == MODE_CMP || ob.mode == MODE_PWM) && pin_d;
    end
  end
endmodule
`default_nettype wire

/* verilog/ctmr_top.sv */
/*
  Compact 10-bit timer: register port, counter with comparators A and P,
  match flags, and the shared output pin pair.
  Assumes a same-clock register master; one-cycle strobes, no waits.
*/
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctmr_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [ctmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ctmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ctmr_pkg::DATA_W-1:0] reg_rdata,
  output logic compare_a_match_flag,
  output logic compare_p_match_flag,
  output logic timer_output_pin_zero,
  output logic timer_output_pin_zero_en,
  output logic timer_output_pin_one,
  output logic timer_output_pin_one_en
);
  import ctmr_pkg::*;

  logic timer_on_q;
  logic on_dly_q;
  logic [PER_W-1:0] period_value_q;
  logic [7:0] ctrl1_q;
  logic [CNT_W-1:0] compare_a_value_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic flag_a_q;
  logic flag_p_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic [1:0] mode;
  logic [1:0] ofn;
  logic output_initial_level;
  logic output_invert;
  logic period_duty_swap;
  logic counter_clear_select;
  logic pwm_mode;
  logic on_rise;
  logic run;
  logic cmpa_nonzero;
  logic [CNT_W:0] inc;
  logic [CNT_W:0] a_target;
  logic [CNT_W:0] p_target;
  logic [CNT_W:0] duty_val;
  logic a_hit;
  logic p_hit;
  logic clear_by_a;
  logic a_evt;
  logic p_evt;
  logic clr_a;
  logic clr_p;
  logic wr_ctrl0;

  ctmr_out_if u_ob ();

  assign mode = ctrl1_q[C1_MODE_LSB +: 2];
  assign ofn = ctrl1_q[C1_OFN_LSB +: 2];
  assign output_initial_level = ctrl1_q[C1_INIT_BIT];
  assign output_invert = ctrl1_q[C1_INV_BIT];
  assign period_duty_swap = ctrl1_q[C1_SWAP_BIT];
  assign counter_clear_select = ctrl1_q[C1_CCS_BIT];
  assign pwm_mode = (mode == MODE_PWM);

  // Counter restart is seen one edge after the enable write lands
  assign on_rise = timer_on_q && !on_dly_q;
  assign run = timer_on_q && !on_rise;

  assign inc = {1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1};
  assign cmpa_nonzero = (compare_a_value_q != CMPA_RST);
  assign a_target = {1'b0, compare_a_value_q};
  // Period code zero means the full 10-bit range
  assign p_target = (period_value_q == PER_RST) ?
    {1'b1, CNT_RST} :
    {1'b0, period_value_q, {PER_SHIFT{1'b0}}};

  ctmr_match #(
    .W(CNT_W + 1)
  ) u_match_a (
    .inc(inc),
    .target(a_target),
    .enable(run && cmpa_nonzero),
    .hit(a_hit)
  );

  ctmr_match #(
    .W(CNT_W + 1)
  ) u_match_p (
    .inc(inc),
    .target(p_target),
    .enable(run),
    .hit(p_hit)
  );

  // PWM lets the swap bit choose the clearing comparator
  assign clear_by_a = pwm_mode ? period_duty_swap : counter_clear_select;
  assign a_evt = a_hit;
  assign p_evt = p_hit && (pwm_mode || !counter_clear_select);

  always_comb begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = CNT_RST;
    end else if (run) begin
      if (clear_by_a ? a_hit : p_hit) begin
        cnt_d = CNT_RST;
      end else begin
        cnt_d = inc[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= CNT_RST;
      on_dly_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      on_dly_q <= timer_on_q;
    end
  end

  // Duty source: compare A normally, period code when swapped
  assign duty_val = period_duty_swap ? p_target : a_target;
  assign u_ob.pwm_active = ({1'b0, cnt_q} < duty_val);
  assign u_ob.mode = mode;
  assign u_ob.ofn = ofn;
  assign u_ob.init_lvl = output_initial_level;
  assign u_ob.invert = output_invert;
  assign u_ob.on_rise = on_rise;
  assign u_ob.a_evt = a_evt;

  ctmr_outgen u_outgen (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ob(u_ob.gen)
  );

  assign timer_output_pin_zero = u_ob.pin_lvl;
  assign timer_output_pin_zero_en = u_ob.pin_en;
  assign timer_output_pin_one = u_ob.pin_lvl;
  assign timer_output_pin_one_en = u_ob.pin_en;

  assign wr_ctrl0 = reg_wr && (reg_addr == REG_CTRL0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_on_q <= 1'b0;
      period_value_q <= PER_RST;
    end else if (wr_ctrl0) begin
      timer_on_q <= reg_wdata[C0_ON_BIT];
      period_value_q <= reg_wdata[C0_PER_LSB +: PER_W];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_q <= CTRL1_RST;
    end else if (reg_wr && reg_addr == REG_CTRL1) begin
      ctrl1_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      compare_a_value_q <= CMPA_RST;
    end else if (reg_wr && reg_addr == REG_CMPA_LO) begin
      compare_a_value_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == REG_CMPA_HI) begin
      compare_a_value_q[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
    end
  end

  // Flags clear by writing one; a same-cycle match still wins
  assign clr_a = reg_wr && reg_addr == REG_FLAGS && reg_wdata[FLG_A_BIT];
  assign clr_p = reg_wr && reg_addr == REG_FLAGS && reg_wdata[FLG_P_BIT];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      flag_a_q <= (flag_a_q && !clr_a) || a_evt;
      flag_p_q <= (flag_p_q && !clr_p) || p_evt;
    end
  end

  assign compare_a_match_flag = flag_a_q;
  assign compare_p_match_flag = flag_p_q;

  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      REG_CTRL0: begin
        rdata_d[C0_ON_BIT] = timer_on_q;
        rdata_d[C0_PER_LSB +: PER_W] = period_value_q;
      end
      REG_CTRL1: rdata_d = ctrl1_q;
      REG_CNT_LO: rdata_d = cnt_q[7:0];
      REG_CNT_HI: rdata_d[CNT_W-9:0] = cnt_q[CNT_W-1:8];
      REG_CMPA_LO: rdata_d = compare_a_value_q[7:0];
      REG_CMPA_HI: rdata_d[CNT_W-9:0] = compare_a_value_q[CNT_W-1:8];
      REG_FLAGS: begin
        rdata_d[FLG_A_BIT] = flag_a_q;
        rdata_d[FLG_P_BIT] = flag_p_q;
      end
      default: rdata_d = '0;
    endcase
  end

  // Data is valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  chk_set_wins: assert property (
    a_evt |=> compare_a_match_flag)
    else $error("A match lost against a clear");

  chk_no_p_flag: assert property (
    (!pwm_mode && counter_clear_select && !compare_p_match_flag) ##1
    (!pwm_mode && counter_clear_select && $stable(ctrl1_q))
    |-> !compare_p_match_flag)
    else $error("P flag raised while A clears");

  chk_clear_a: assert property (
    (run && clear_by_a && a_hit) |=> (cnt_q == CNT_RST))
    else $error("A match did not clear counter");

  chk_clear_p: assert property (
    (run && !clear_by_a && p_hit) |=> (cnt_q == CNT_RST))
    else $error("P match did not clear counter");

  chk_no_clear_p: assert property (
    (run && clear_by_a && p_hit && !a_hit &&
     period_value_q != PER_RST) |=> (cnt_q == $past(inc[CNT_W-1:0])))
    else $error("P match cleared while A selected");

  chk_on_rise_zero: assert property (
    (!timer_on_q ##1 timer_on_q) |=> (cnt_q == CNT_RST))
    else $error("Counter not zero after enable");

  chk_count_up: assert property (
    (run && !a_hit && !p_hit) |=> (cnt_q == $past(inc[CNT_W-1:0])))
    else $error("Counter failed to advance");

  chk_hold_off: assert property (
    (!timer_on_q ##1 !timer_on_q) |-> $stable(cnt_q))
    else $error("Counter moved while off");

  chk_ovf_no_a: assert property (
    (!cmpa_nonzero && cnt_q == {CNT_W{1'b1}} && run) |-> !a_evt)
    else $error("A flag on overflow with zero compare");

  chk_ovf_wrap: assert property (
    (run && cnt_q == {CNT_W{1'b1}} && period_value_q == PER_RST)
    |=> (cnt_q == CNT_RST))
    else $error("Counter did not wrap at maximum");

  chk_timer_undriven: assert property (
    (mode == MODE_TMR) |=> !timer_output_pin_zero_en &&
    !timer_output_pin_one_en)
    else $error("Pin driven in timer mode");

  chk_pwm_forced: assert property (
    (pwm_mode && ofn == OFN_PWM_ACT) |=>
    (timer_output_pin_zero ==
     ($past(output_initial_level) ^ $past(output_invert))))
    else $error("Forced active level wrong");

  chk_pwm_wave: assert property (
    (pwm_mode && ofn == OFN_PWM_WAVE) |=>
    (timer_output_pin_zero == (($past(u_ob.pwm_active) ~^
     $past(output_initial_level)) ^ $past(output_invert))))
    else $error("PWM level does not follow duty");

  chk_full_duty: assert property (
    (run && pwm_mode && !period_duty_swap && a_target >= p_target &&
     period_value_q != PER_RST) |-> u_ob.pwm_active)
    else $error("Duty at period not held active");

  chk_cmp_keep: assert property (
    (mode == MODE_CMP && ofn == 2'h0 && !on_rise) ##1
    (mode == MODE_CMP && $stable(ctrl1_q) && !on_rise)
    |=> $stable(timer_output_pin_zero))
    else $error("Pin changed with no-change function");

  chk_init_level: assert property (
    (on_rise && mode == MODE_CMP) |=>
    (timer_output_pin_zero ==
     ($past(output_initial_level) ^ $past(output_invert))))
    else $error("Initial level not applied on enable");

  chk_read_data: assert property (
    (reg_rd && reg_addr == REG_CTRL1) |=> (reg_rdata == $past(ctrl1_q)))
    else $error("Read data not presented next cycle");
endmodule
`default_nettype wire

/* tb/ctmr_tb.sv */
/*
  Self-checking bench for the compact timer top: registers, compare
  mode, timer mode and PWM shaping seen at the pins and flags.
  Assumes the design package and the design's own inline assertions.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctmr_pkg::*;
  `define CHK(nm, ex, got) begin total_checks++; \
    if ((got) !== (ex)) begin fail_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
  typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] e;} ctmr_rw_s;
  typedef struct {logic [7:0] c1; logic en; logic pin;} ctmr_cm_s;
  typedef struct {logic [7:0] c1; logic [2:0] per; logic [9:0] a;
    logic [10:0] win; logic [10:0] hi; logic fa;} ctmr_pw_s;
  logic clk_sys;
  logic arst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic fa;
  logic fp;
  logic pin0;
  logic pin0_en;
  logic pin1;
  logic pin1_en;
  int fail_count = 0;
  int total_checks = 0;
  ctmr_rw_s rw_rows [9] = '{'{REG_CTRL1, 8'hAB, 8'hAB},
    '{REG_CMPA_LO, 8'hC3, 8'hC3}, '{REG_CMPA_HI, 8'hFF, 8'h03},
    '{REG_CTRL0, 8'h05, 8'h05}, '{3'h7, 8'hFF, 8'h00},
    '{REG_CNT_LO, 8'hFF, 8'h00}, '{REG_CNT_HI, 8'hFF, 8'h00},
    '{REG_FLAGS, 8'hFF, 8'h00}, '{REG_CTRL1, 8'h00, 8'h00}};
  // Inverted row sits last so the last row leaves the pin low
  ctmr_cm_s cm_rows [5] = '{'{8'h09, 1'b1, 1'b1}, '{8'hF9, 1'b0, 1'b0},
    '{8'h19, 1'b1, 1'b0}, '{8'h21, 1'b1, 1'b1}, '{8'h0D, 1'b1, 1'b0}};
  ctmr_pw_s pw_rows [9] = '{'{8'hA9, 3'h1, 10'd32, 11'd128, 11'd32, 1'b1},
    '{8'hA8, 3'h2, 10'd32, 11'd256, 11'd32, 1'b1},
    '{8'hA8, 3'h0, 10'd32, 11'd1024, 11'd32, 1'b1},
    '{8'hA8, 3'h1, 10'd200, 11'd128, 11'd128, 1'b0},
    '{8'hAC, 3'h1, 10'd32, 11'd128, 11'd96, 1'b1},
    '{8'hA0, 3'h1, 10'd32, 11'd128, 11'd96, 1'b1},
    '{8'hAB, 3'h1, 10'd256, 11'd256, 11'd128, 1'b1},
    '{8'h88, 3'h1, 10'd32, 11'd128, 11'd0, 1'b1},
    '{8'h98, 3'h1, 10'd32, 11'd128, 11'd128, 1'b1}};

  ctmr_top dut_u (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .compare_a_match_flag(fa),
    .compare_p_match_flag(fp),
    .timer_output_pin_zero(pin0),
    .timer_output_pin_zero_en(pin0_en),
    .timer_output_pin_one(pin1),
    .timer_output_pin_one_en(pin1_en)
  );

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Counter restarts from zero on each enable, so windows are aligned
  task automatic start(input logic [7:0] c1, input logic [2:0] per,
      input logic [9:0] a);
    wr(REG_CTRL0, 8'h00);
    wr(REG_CTRL1, c1);
    wr(REG_CMPA_LO, a[7:0]);
    wr(REG_CMPA_HI, {6'h00, a[9:8]});
    wr(REG_FLAGS, 8'h03);
    wr(REG_CTRL0, {5'h01, per});
  endtask

  // Any window of whole periods holds the same active count
  task automatic measure(input int n, output int hi, output int tog);
    logic last;
    hi = 0;
    tog = 0;
    last = pin0;
    repeat (n) begin
      tick(1);
      if (pin0 === 1'b1) hi++;
      if (pin0 !== last) tog++;
      last = pin0;
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_p(input int lim);
    int k;
    for (k = 0; k < lim && fp !== 1'b1; k++) tick(1);
    if (k == lim) begin
      fail_count++;
      $display("MISMATCH wait_p exp 1 got 0");
      summarize();
    end
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] d2;
    int hi;
    int tog;
    arst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(1);
    `CHK("rst_pin_en", 1'b1, pin0_en)
    `CHK("rst_pin", 1'b0, pin0)
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], d);
      `CHK("rst_reg", 8'h00, d)
    end
    foreach (rw_rows[i]) begin
      wr(rw_rows[i].a, rw_rows[i].d);
      rd(rw_rows[i].a, d);
      `CHK("reg_rw", rw_rows[i].e, d)
    end
    foreach (cm_rows[i]) begin
      start(cm_rows[i].c1, 3'h0, 10'h003);
      tick(20);
      `CHK("cm_en", cm_rows[i].en, pin0_en)
      if (cm_rows[i].en) `CHK("cm_pin", cm_rows[i].pin, pin0)
      `CHK("cm_pin1", pin0, pin1)
      `CHK("cm_fa", 1'b1, fa)
      `CHK("cm_fp", 1'b0, fp)
    end
    start(8'h39, 3'h1, 10'd200);
    tick(50);
    measure(600, hi, tog);
    `CHK("cm_toggles", 32'd3, tog)
    `CHK("cm_no_p", 1'b0, fp)
    // Odd toggle count leaves the pin low, so the restore is visible
    wr(REG_CTRL0, 8'h00);
    #1;
    `CHK("toggled_low", 1'b0, pin0)
    wr(REG_CTRL0, 8'h09);
    tick(1);
    `CHK("init_lvl", 1'b1, pin0)
    start(8'h00, 3'h1, 10'h003);
    wait_p(140);
    `CHK("pclr_fa", 1'b1, fa)
    start(8'h00, 3'h0, 10'h003);
    tick(1000);
    `CHK("ovf_early", 1'b0, fp)
    wait_p(40);
    start(8'h01, 3'h1, 10'h000);
    tick(1100);
    `CHK("a0_fa", 1'b0, fa)
    `CHK("a0_fp", 1'b0, fp)
    foreach (pw_rows[i]) begin
      start(pw_rows[i].c1, pw_rows[i].per, pw_rows[i].a);
      tick(16);
      measure(int'(pw_rows[i].win), hi, tog);
      `CHK("pwm_hi", pw_rows[i].hi, hi[10:0])
      `CHK("pwm_hi_src", pw_rows[i].hi, hi[10:0])
      `CHK("pwm_en", 1'b1, pin0_en)
      `CHK("pwm_fa", pw_rows[i].fa, fa)
      `CHK("pwm_fp", 1'b1, fp)
    end
    wr(REG_CTRL0, 8'h00);
    rd(REG_CNT_LO, d);
    tick(5);
    rd(REG_CNT_LO, d2);
    `CHK("cnt_hold", d, d2)
    wr(REG_CTRL0, 8'h08);
    wr(REG_CTRL0, 8'h00);
    rd(REG_CNT_LO, d);
    `CHK("cnt_restart", 1'b1, d < 8'h04)
    rd(REG_CNT_HI, d);
    `CHK("cnt_restart_hi", 8'h00, d)
    summarize();
  end
endmodule
`default_nettype wire
